/* File: design/quad_irq_pkg.sv */
// constants shared by the interrupt summary and mask block
package quad_irq_pkg;
	localparam int NUM_UART = 4;
	localparam int CODE_W = 6;
	localparam int NUM_PIN = 12;

	// register word offsets, byte addresses
	localparam logic [7:0] OFS_RX_LEVEL = 8'h10;
	localparam logic [7:0] OFS_TX_LEVEL = 8'h14;
	localparam logic [7:0] OFS_SRC_SUM = 8'h18;
	localparam logic [7:0] OFS_GLOBAL = 8'h1C;

	// interrupt-source codes that still allow good data, reset values and the no-pending bit position
	localparam logic [5:0] CODE_NONE = 6'h01;
	localparam logic [5:0] CODE_RX_AVAIL = 6'h04;
	localparam logic [5:0] CODE_RX_TIMEOUT = 6'h0C;
	localparam logic [5:0] CODE_TX_EMPTY = 6'h02;
	localparam logic [5:0] CODE_RESET = 6'h01;
	localparam logic GOOD_RESET = 1'b1;
	localparam int NOPEND_BIT = 0;

	// source-summary layout
	localparam int RSVD_W = 3;

	// global status and mask layout
	localparam int MASK_UART_LSB = 16;
	localparam int MASK_AUX0_BIT = 20;
	localparam int MASK_AUX1_BIT = 21;
	localparam int MASK_PIN_LSB = 22;
	localparam int PIN_MASK_LO_W = 2;
	localparam int PIN_MASK_HI_W = 8;
	localparam logic [3:0] MASK_UART_RESET = 4'hF;
	localparam logic [9:0] MASK_PIN_RESET = 10'h3FF;
	localparam logic MASK_AUX0_RESET = 1'b1;
	localparam logic MASK_MIO1_RESET = 1'b1;
	localparam logic MASK_PD_RESET = 1'b0;

	// byte lanes of the 32-bit word
	localparam int LANE_STATUS = 0;
	localparam int LANE_MASK_LO = 2;
	localparam int LANE_MASK_HI = 3;

	// function mode and power-down filter values
	localparam logic [1:0] MODE_PARALLEL = 2'h1;
	localparam logic [1:0] MODE_SUBSYS_ID = 2'h2;
	localparam logic [1:0] FILTER_OFF = 2'h0;

	function automatic logic isGoodCode(input logic [5:0] code);
		isGoodCode = (code == CODE_NONE) || (code == CODE_RX_AVAIL) ||
			(code == CODE_RX_TIMEOUT) || (code == CODE_TX_EMPTY);
	endfunction
endpackage

/* File: design/good_data_eval.sv */
// per-channel source code capture and good-data flag
`timescale 1ns/10ps
module good_data_eval
	import quad_irq_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [CODE_W-1:0] codeIn,
	input wire logic fifoErr,
	input wire logic overrun,
	output logic [CODE_W-1:0] codeQ,
	output logic goodQ
);
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			codeQ <= CODE_RESET;
			goodQ <= GOOD_RESET;
		end
		else
		begin
			codeQ <= codeIn;
			// live line status: once it is read and cleared, the flag returns
			goodQ <= isGoodCode(codeIn) && !fifoErr && !overrun;
		end
	end
endmodule

/* File: design/pin_conditioner.sv */
// polarity selection for the multi-purpose pins
`timescale 1ns/10ps
module pin_conditioner #(
	parameter int N = 12
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [N-1:0] pinLevel,
	input wire logic [N-1:0] invert,
	output logic [N-1:0] pinState
);
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pinState <= '0;
		else
			pinState <= pinLevel ^ invert;
	end
endmodule

/* File: design/quad_uart_irq_summary_mask.sv */
// interrupt source summary, global status and masks, PCI interrupt drive
`timescale 1ns/10ps
// Functional notes
// - source summary holds four six-bit source codes, each resetting to 01h
// - bits 30:27 are good-data flags reset high; bit 31 is their AND
// - good data needs code none, rx available, rx timeout or tx empty
// - good data needs the fifo error line status bit clear
// - good data needs the overrun line status bit clear
// - line status read clears fifo error; software then drains the fifo
// - levels, summary and global status sit at words 10h to 1Ch
// - status bits 3:0 are the inverted no-pending bits of each channel
// - bit 4 is pin 0, or parallel interrupt (reset 0) in mode 01
// - bit 5 is pin 1 with filter 00, else sticky read-cleared request
// - status bits 15:6 follow pins 11 down to 2
// - each pin state is the level or its inverse by polarity config
// - mask bits 19:16 gate each channel's interrupt, reset Fh
// - mask bit 20 gates pin 0, or parallel interrupt in mode 01
// - mask bit 21 gates pin 1 (reset 1) or power-down (reset 0)
// - mask bits 31:22 gate pins 11 down to 2, reset 3FFh
// - mode 10 blocks every pin interrupt regardless of masks
// - mask defaults other than the power-down mask can be replaced by values from configuration memory
// - no interrupt right after reset since channel codes show none pending
module quad_uart_irq_summary_mask
	import quad_irq_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic [3:0] regByteEn,
	input wire logic regRead,
	input wire logic regWrite,
	input wire logic [31:0] regWriteData,
	output logic [31:0] regReadData,
	output logic regReadValid,
	input wire logic [31:0] rxLevelShadow,
	input wire logic [31:0] txLevelShadow,
	input wire logic [NUM_UART*CODE_W-1:0] irqSourceCode,
	input wire logic [NUM_UART-1:0] lineStatusFifoErr,
	input wire logic [NUM_UART-1:0] lineStatusOverrun,
	input wire logic [1:0] functionMode,
	input wire logic [1:0] pdFilterTime,
	input wire logic [NUM_PIN-1:0] pinPolarityConfig,
	input wire logic [NUM_PIN-1:0] multiPurposePin,
	input wire logic parallelIrq,
	input wire logic powerDownReq,
	input wire logic maskLoad,
	input wire logic [15:0] maskLoadValue,
	input wire logic irqPinIn,
	output logic irqPinOut,
	output logic irqPinOe
);
	logic [NUM_UART*CODE_W-1:0] codeQ;
	logic [NUM_UART-1:0] goodQ;
	logic [NUM_UART-1:0] uartStat;
	logic [NUM_PIN-1:0] pinState;
	logic parIrq_reg;
	logic pdSticky_reg;
	logic [3:0] uartMask_reg;
	logic aux0Mask_reg;
	logic mio1Mask_reg;
	logic pdMask_reg;
	logic [9:0] pinMask_reg;
	logic [31:0] regReadData_reg;
	logic regReadValid_reg;
	logic irqPinOe_reg;
	logic irqPinOut_reg;
	logic parallelMode;
	logic subsysMode;
	logic filterOn;
	logic aux0Stat;
	logic aux1Stat;
	logic aux1Mask;
	logic uartHit;
	logic pinHit;
	logic auxHit;
	logic gisRead;
	logic [15:0] globalStat;
	logic [31:0] uisWord;
	logic [31:0] gisWord;

	genvar ch;
	generate
		for (ch = 0; ch < NUM_UART; ch++)
		begin : g_chan
			good_data_eval u_gd (
				.clk(clk),
				.rst(rst),
				.codeIn(irqSourceCode[ch*CODE_W +: CODE_W]),
				.fifoErr(lineStatusFifoErr[ch]),
				.overrun(lineStatusOverrun[ch]),
				.codeQ(codeQ[ch*CODE_W +: CODE_W]),
				.goodQ(goodQ[ch])
			);
			// channel line is active while no-pending bit is low
			assign uartStat[ch] = ~codeQ[ch*CODE_W + NOPEND_BIT];
		end
	endgenerate

	pin_conditioner #(
		.N(NUM_PIN)
	) u_pins (
		.clk(clk),
		.rst(rst),
		.pinLevel(multiPurposePin),
		.invert(pinPolarityConfig),
		.pinState(pinState)
	);

	assign parallelMode = (functionMode == MODE_PARALLEL);
	assign subsysMode = (functionMode == MODE_SUBSYS_ID);
	assign filterOn = (pdFilterTime != FILTER_OFF);
	assign aux0Stat = parallelMode ? parIrq_reg : pinState[0];
	assign aux1Stat = filterOn ? pdSticky_reg : pinState[1];
	assign aux1Mask = filterOn ? pdMask_reg : mio1Mask_reg;
	assign globalStat = {pinState[11:2], aux1Stat, aux0Stat, uartStat};

	// bit 31 is the AND, 26:24 reserved zero
	assign uisWord = {&goodQ, goodQ, {RSVD_W{1'b0}}, codeQ};
	assign gisWord = {pinMask_reg, aux1Mask, aux0Mask_reg, uartMask_reg,
		globalStat};

	assign gisRead = regRead && (regAddr == OFS_GLOBAL) &&
		regByteEn[LANE_STATUS];

	// interrupt sources split so mode 10 can mute only pin-driven ones
	assign uartHit = |(uartStat & uartMask_reg);
	assign pinHit = !subsysMode && (
		|(pinState[11:2] & pinMask_reg) ||
		(!parallelMode && pinState[0] && aux0Mask_reg) ||
		(!filterOn && pinState[1] && mio1Mask_reg));
	assign auxHit = (parallelMode && parIrq_reg && aux0Mask_reg) ||
		(filterOn && pdSticky_reg && pdMask_reg);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			parIrq_reg <= 1'b0;
		else
			parIrq_reg <= parallelIrq;
	end

	// a request in the cycle of the clearing read wins over the clear
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pdSticky_reg <= 1'b0;
		else if (!filterOn)
			pdSticky_reg <= 1'b0;
		else if (powerDownReq)
			pdSticky_reg <= 1'b1;
		else if (gisRead)
			pdSticky_reg <= 1'b0;
	end

	// configuration memory load takes priority over register writes; it can run in any cycle after reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			uartMask_reg <= MASK_UART_RESET;
			aux0Mask_reg <= MASK_AUX0_RESET;
			mio1Mask_reg <= MASK_MIO1_RESET;
			pdMask_reg <= MASK_PD_RESET;
			pinMask_reg <= MASK_PIN_RESET;
		end
		else if (maskLoad)
		begin
			uartMask_reg <= maskLoadValue[3:0];
			aux0Mask_reg <= maskLoadValue[MASK_AUX0_BIT-MASK_UART_LSB];
			mio1Mask_reg <= maskLoadValue[MASK_AUX1_BIT-MASK_UART_LSB];
			pinMask_reg <= maskLoadValue[15:6];
		end
		else if (regWrite && (regAddr == OFS_GLOBAL))
		begin
			if (regByteEn[LANE_MASK_LO])
			begin
				uartMask_reg <= regWriteData[MASK_UART_LSB +: 4];
				aux0Mask_reg <= regWriteData[MASK_AUX0_BIT];
				if (filterOn)
					pdMask_reg <= regWriteData[MASK_AUX1_BIT];
				else
					mio1Mask_reg <= regWriteData[MASK_AUX1_BIT];
				pinMask_reg[PIN_MASK_LO_W-1:0] <=
					regWriteData[MASK_PIN_LSB +: PIN_MASK_LO_W];
			end
			if (regByteEn[LANE_MASK_HI])
				pinMask_reg[9:PIN_MASK_LO_W] <=
					regWriteData[MASK_PIN_LSB+PIN_MASK_LO_W +: PIN_MASK_HI_W];
		end
	end

	// levels precede status words so a burst sees counts first
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			regReadData_reg <= '0;
			regReadValid_reg <= 1'b0;
		end
		else
		begin
			regReadValid_reg <= regRead;
			if (!regRead)
				regReadData_reg <= regReadData_reg;
			else if (regAddr == OFS_RX_LEVEL)
				regReadData_reg <= rxLevelShadow;
			else if (regAddr == OFS_TX_LEVEL)
				regReadData_reg <= txLevelShadow;
			else if (regAddr == OFS_SRC_SUM)
				regReadData_reg <= uisWord;
			else if (regAddr == OFS_GLOBAL)
				regReadData_reg <= gisWord;
			else
				regReadData_reg <= '0;
		end
	end

	// open-drain: the pin is only ever pulled low
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			irqPinOe_reg <= 1'b0;
			irqPinOut_reg <= 1'b0;
		end
		else
		begin
			irqPinOe_reg <= uartHit || pinHit || auxHit;
			irqPinOut_reg <= 1'b0;
		end
	end

	assign regReadData = regReadData_reg;
	assign regReadValid = regReadValid_reg;
	assign irqPinOe = irqPinOe_reg;
	assign irqPinOut = irqPinOut_reg;

	// helper state read only by the checks below
	logic [1:0] resetAge_reg;
	logic [NUM_UART-1:0] codeForbid;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			resetAge_reg <= 2'h0;
		else if (resetAge_reg != 2'h3)
			resetAge_reg <= resetAge_reg + 2'h1;
	end
	always_comb
	begin
		for (int i = 0; i < NUM_UART; i++)
			codeForbid[i] = !isGoodCode(irqSourceCode[i*CODE_W +: CODE_W]);
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_sumRead;
		regRead && (regAddr == OFS_SRC_SUM) ##1 regReadValid;
	endsequence
	sequence s_gisRead;
		regRead && (regAddr == OFS_GLOBAL) ##1 regReadValid;
	endsequence
	sequence s_pdReq;
		filterOn && powerDownReq && (pdFilterTime == $past(pdFilterTime));
	endsequence

	property p_sumLayout;
		s_sumRead |-> (regReadData[31] == &regReadData[30:27]) &&
			(regReadData[26:24] == 3'h0);
	endproperty
	a_sumLayout: assert property (p_sumLayout)
		else $error("summary AND bit or reserved field wrong");

	property p_badCode;
		(|codeForbid) |=> ((goodQ & $past(codeForbid)) == 4'h0);
	endproperty
	a_badCode: assert property (p_badCode)
		else $error("good data set with a disallowed source code");

	property p_fifoErr;
		(|lineStatusFifoErr) |=> ((goodQ & $past(lineStatusFifoErr)) == 4'h0);
	endproperty
	a_fifoErr: assert property (p_fifoErr)
		else $error("good data set while fifo error is high");

	property p_overrun;
		(|lineStatusOverrun) |=> ((goodQ & $past(lineStatusOverrun)) == 4'h0);
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("good data set while overrun is high");

	property p_gisLines;
		s_gisRead |-> regReadData[3:0] == ~{$past(codeQ[18]),
			$past(codeQ[12]), $past(codeQ[6]), $past(codeQ[0])};
	endproperty
	a_gisLines: assert property (p_gisLines)
		else $error("status lines not inverse of no-pending bits");

	property p_pdSticky;
		s_pdReq |=> pdSticky_reg ##1 (pdSticky_reg || !filterOn ||
			$past(gisRead));
	endproperty
	a_pdSticky: assert property (p_pdSticky)
		else $error("power-down request flag not held");

	property p_maskWrite;
		regWrite && (regAddr == OFS_GLOBAL) && regByteEn[LANE_MASK_LO] &&
			!maskLoad |=> (uartMask_reg == $past(regWriteData[19:16]));
	endproperty
	a_maskWrite: assert property (p_maskWrite)
		else $error("channel mask not written");

	property p_subsysMute;
		subsysMode && !uartHit && !auxHit |=> !irqPinOe;
	endproperty
	a_subsysMute: assert property (p_subsysMute)
		else $error("pin interrupt passed in subsystem id mode");

	property p_noIrqAfterReset;
		(resetAge_reg == 2'h0) |=> !irqPinOe;
	endproperty
	a_noIrqAfterReset: assert property (p_noIrqAfterReset)
		else $error("interrupt driven right after reset");

	property p_irqFollows;
		!(uartHit || pinHit || auxHit) ##1 (uartHit || pinHit || auxHit)
			|=> irqPinOe ##0 !$past(irqPinOe);
	endproperty
	a_irqFollows: assert property (p_irqFollows)
		else $error("interrupt pin not raised one cycle after source");
endmodule

/* File: sim/host_driver_model.sv */
// host driver model: register strobes, writes and burst reads
`timescale 1ns/10ps
module host_driver_model
(
	input wire logic clk,
	output logic [7:0] regAddr,
	output logic [3:0] regByteEn,
	output logic regRead,
	output logic regWrite,
	output logic [31:0] regWriteData,
	input wire logic [31:0] regReadData
);
	logic [31:0] rdData [4];
	initial
	begin
		regAddr = 8'h00;
		regByteEn = 4'h0;
		regRead = 1'b0;
		regWrite = 1'b0;
		regWriteData = 32'h0;
	end
	// levels come before status words, so good flags cover counted bytes
	task automatic rd(input logic [7:0] a, input int n);
		for (int i = 0; i < n + 2; i++)
		begin
			@(posedge clk);
			if (i >= 2)
				rdData[i-2] = regReadData;
			regRead <= (i < n);
			regAddr <= a + 8'(4 * i);
			regByteEn <= 4'hF;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regByteEn <= 4'hC;
		regWriteData <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
endmodule

/* File: sim/test_quad_uart_irq_summary_mask.sv */
// self-checking bench for the interrupt summary and mask block
`timescale 1ns/10ps
module test_quad_uart_irq_summary_mask;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] regAddr;
	logic [3:0] regByteEn;
	logic regRead, regWrite, regReadValid;
	logic [31:0] regWriteData, regReadData;
	logic [31:0] rxLevelShadow, txLevelShadow;
	logic [23:0] irqSourceCode;
	logic [3:0] lineStatusFifoErr, lineStatusOverrun;
	logic [1:0] functionMode, pdFilterTime;
	logic [11:0] pinPolarityConfig, multiPurposePin;
	logic parallelIrq, powerDownReq, maskLoad;
	logic [15:0] maskLoadValue;
	logic irqPinOut, irqPinOe;
	wire logic irqLine;
	int mismatches = 0;
	int checksDone = 0;
	int cycles = 0;
	logic readPend = 1'b0;
	typedef struct packed {
		logic [23:0] code;
		logic [3:0] fe;
		logic [3:0] ov;
		logic [31:0] sum;
		logic [3:0] st;
	} row_s;
	row_s rows [5] = '{
		'{24'h041041, 4'h0, 4'h0, 32'hF8041041, 4'h0},
		'{24'h042304, 4'h0, 4'h0, 32'hF8042304, 4'h7},
		'{24'h046041, 4'h0, 4'h0, 32'h58046041, 4'h4},
		'{24'h041041, 4'h2, 4'h0, 32'h68041041, 4'h0},
		'{24'h041041, 4'h0, 4'h8, 32'h38041041, 4'h0}
	};
	// pulled-up open-drain line, low while the block drives it
	assign irqLine = ~irqPinOe;
	always #5 clk = ~clk;
	quad_uart_irq_summary_mask dut (.clk, .rst, .regAddr, .regByteEn,
		.regRead, .regWrite, .regWriteData, .regReadData, .regReadValid,
		.rxLevelShadow, .txLevelShadow, .irqSourceCode, .lineStatusFifoErr,
		.lineStatusOverrun, .functionMode, .pdFilterTime, .pinPolarityConfig,
		.multiPurposePin, .parallelIrq, .powerDownReq, .maskLoad,
		.maskLoadValue, .irqPinIn(irqLine), .irqPinOut, .irqPinOe);
	host_driver_model host (.clk, .regAddr, .regByteEn, .regRead,
		.regWrite, .regWriteData, .regReadData);
	task automatic chkW(string nm, logic [31:0] e, logic [31:0] g);
		checksDone++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chkB(string nm, logic e, logic g);
		checksDone++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// a read answer stands exactly one cycle after its request
	always @(posedge clk)
		readPend <= regRead && !rst;
	always @(negedge clk)
	begin
		if (!rst && (readPend || regReadValid))
			chkB("read valid", readPend, regReadValid);
	end
	// pin sources pass two registers before the pin driver
	task automatic wait4();
		repeat (4) @(posedge clk);
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			summarize();
		end
	end
	initial
	begin
		rxLevelShadow = 32'h11223344;
		txLevelShadow = 32'h55667788;
		irqSourceCode = 24'h041041;
		lineStatusFifoErr = 4'h0;
		lineStatusOverrun = 4'h0;
		functionMode = 2'h0;
		pdFilterTime = 2'h0;
		pinPolarityConfig = 12'h000;
		multiPurposePin = 12'h000;
		parallelIrq = 1'b0;
		powerDownReq = 1'b0;
		maskLoad = 1'b0;
		maskLoadValue = 16'hA5F0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chkB("oe after reset", 1'b0, irqPinOe);
		chkB("pin out level", 1'b0, irqPinOut);
		host.rd(8'h18, 2);
		chkW("summary reset", 32'hF8041041, host.rdData[0]);
		chkW("mask reset", 32'hFFFF0000, host.rdData[1]);
		$display("test reset done");
		foreach (rows[i])
		begin
			irqSourceCode <= rows[i].code;
			lineStatusFifoErr <= rows[i].fe;
			lineStatusOverrun <= rows[i].ov;
			host.rd(8'h10, 4);
			chkW("rx level", 32'h11223344, host.rdData[0]);
			chkW("tx level", 32'h55667788, host.rdData[1]);
			chkW("summary", rows[i].sum, host.rdData[2]);
			chkW("uart bits", 32'(rows[i].st), 32'(host.rdData[3][3:0]));
			chkB("uart irq", |rows[i].st, irqPinOe);
			$display("test row %0d done", i);
		end
		lineStatusOverrun <= 4'h0;
		multiPurposePin <= 12'h005;
		pinPolarityConfig <= 12'h001;
		wait4();
		chkB("pin irq", 1'b1, irqPinOe);
		host.rd(8'h1C, 1);
		chkW("pin status", 32'hFFFF0040, host.rdData[0]);
		functionMode <= 2'h2;
		wait4();
		chkB("mode 10 irq", 1'b0, irqPinOe);
		functionMode <= 2'h0;
		host.wr(8'h1C, 32'h0);
		wait4();
		chkB("masked irq", 1'b0, irqPinOe);
		host.rd(8'h1C, 2);
		chkW("masks clear", 32'h00000040, host.rdData[0]);
		chkW("unmapped", 32'h0, host.rdData[1]);
		$display("test pins done");
		functionMode <= 2'h1;
		parallelIrq <= 1'b1;
		multiPurposePin <= 12'h001;
		host.wr(8'h1C, 32'h00100000);
		wait4();
		chkB("parallel irq", 1'b1, irqPinOe);
		host.rd(8'h1C, 1);
		chkW("parallel", 32'h00100010, host.rdData[0]);
		parallelIrq <= 1'b0;
		functionMode <= 2'h0;
		pdFilterTime <= 2'h1;
		host.wr(8'h1C, 32'h00200000);
		powerDownReq <= 1'b1;
		@(posedge clk);
		powerDownReq <= 1'b0;
		wait4();
		chkB("pd irq", 1'b1, irqPinOe);
		host.rd(8'h1C, 1);
		chkW("pd set", 32'h00200020, host.rdData[0]);
		host.rd(8'h1C, 1);
		chkW("pd cleared", 32'h00200000, host.rdData[0]);
		wait4();
		chkB("pd irq gone", 1'b0, irqPinOe);
		$display("test power-down done");
		pdFilterTime <= 2'h0;
		maskLoad <= 1'b1;
		@(posedge clk);
		maskLoad <= 1'b0;
		host.rd(8'h1C, 1);
		chkW("mask load", 32'hA5F00000, host.rdData[0]);
		$display("test mask load done");
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		host.rd(8'h18, 2);
		chkW("summary again", 32'hF8041041, host.rdData[0]);
		chkW("masks again", 32'hFFFF0000, host.rdData[1]);
		chkB("oe again", 1'b0, irqPinOe);
		$display("test second reset done");
		summarize();
	end
endmodule
